// ==== core/elts_defines.svh ====
// Contract
// (RULE1) address latent test uses source at address xor mask and destination at address
// (RULE2) software starts the xor mask at one for single-bit injection
// (RULE3) per step: save source, write fixed pattern coded, save destination, copy source
// (RULE4) checked destination read fails unless uncorrectable set and correctable clear
// (RULE5) restore both entries directly, read back and compare, then advance mask; the code advances the mask between source and destination read-backs
// (RULE6) address latent outer loop runs twice per bank
// (RULE7) the temporary hold register carries the source copy into the destination
// (RULE8) double-bit injection: software sets mask 0x3, loop count bits minus two
// (RULE9) single-bit tests: software sets loop count to address bits minus one
// (RULE10) bank counter start is start bank times two plus one, above end times two
// (RULE11) testing all banks, software programs end bank number zero
// (RULE12) mask shifts left on even outer passes and right on odd passes
// (RULE13) final read-check decrements loop counter and branches back until exhausted
// (RULE14) single-point test writes fixed pattern at address xor mask via generation path
// (RULE15) single-point test writes the selected fixed pattern, not existing contents
// (RULE16) single-point checked read fails if any error is reported
// (RULE17) single-point test restores saved entry directly and verifies readback
// (RULE18) data latent test builds pattern from base, injects into data and code bits
// (RULE19) data latent inner loop iterates once per data plus code bit
// (RULE20) each test runs with base pattern and with its inverse
// (RULE21) pattern update inverts the base pattern held in row address between passes
// (RULE22) bank mode: bank counter is outer loop and supplies bank-select bits
// (RULE23) any failed compare or unexpected flag sets a sticky failure bit
// (RULE24) access path is encoded in the upper array-select bits of each request
`ifndef ELTS_DEFINES_SVH
`define ELTS_DEFINES_SVH
`define ELTS_REG_CTRL 4'h0
`define ELTS_REG_LOOP 4'h4
`define ELTS_REG_ADDR 4'h8
`define ELTS_REG_BANK 4'hC
`define ELTS_REG_MASK 5'h10
`define ELTS_REG_FPAT 5'h14
`define ELTS_REG_STAT 5'h18
`define ELTS_CTRL_START 0
`define ELTS_CTRL_ALG_LO 1
`define ELTS_CTRL_ALG_HI 2
`define ELTS_CTRL_BANKEN 3
`define ELTS_CTRL_HOLDDIS 4
`define ELTS_CTRL_POL 5
`define ELTS_PATH_DIRECT 2'h0
`define ELTS_PATH_GEN 2'h1
`define ELTS_PATH_CHECK 2'h2
`define ELTS_PATH_CORR 2'h3
`define ELTS_ALG_ADDR_LATENT 2'h0
`define ELTS_ALG_ADDR_SPOINT 2'h1
`define ELTS_ALG_DATA_LATENT 2'h2
`endif

// ==== core/elts_pkg.sv ====
package elts_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h00, ST_SAVE_SRC = 5'h01, ST_GEN_WR = 5'h02,
      ST_SAVE_DST = 5'h03, ST_COPY_RD = 5'h04, ST_COPY_WR = 5'h05,
      ST_CHK_RD = 5'h06, ST_RST_SRC = 5'h07, ST_RST_DST = 5'h08,
      ST_VER_SRC = 5'h09, ST_VER_DST = 5'h0A, ST_SHIFT = 5'h0B,
      ST_LOOP = 5'h0C, ST_PUP = 5'h0D, ST_LAST = 5'h0E,
      ST_DL_INJ = 5'h0F, ST_DL_CORR = 5'h10
   } elts_state_type;
   typedef struct packed {
      logic req;
      logic wr;
      logic [1:0] path;
      logic [15:0] addr;
      logic [31:0] wdata;
   } elts_mem_req_type;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic ue_flag;
      logic ce_flag;
   } elts_mem_rsp_type;
endpackage : elts_pkg

// ==== core/elts_mem_port.sv ====
`timescale 1ns/1ps
// one-outstanding request holder toward the protected array
module elts_mem_port (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // from sequencer
   input wire logic issue,
   input wire elts_pkg::elts_mem_req_type cmd,
   output logic busy,
   // to array
   output elts_pkg::elts_mem_req_type mem_req,
   input wire elts_pkg::elts_mem_rsp_type mem_rsp
);
   import elts_pkg::*;
   typedef struct packed {
      elts_mem_req_type req;
   } elts_port_state_type;
   elts_port_state_type state;
   elts_port_state_type next_state;
   // hold request until the array acks; new issue only when idle
   always_comb begin
      next_state = state;
      if (state.req.req && mem_rsp.ack) begin
         next_state.req.req = 1'b0;
      end else if (!state.req.req && issue) begin
         next_state.req = cmd;
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign mem_req = state.req;
   assign busy = state.req.req;
endmodule : elts_mem_port

// ==== core/elts_sequencer.sv ====
`timescale 1ns/1ps
`include "elts_defines.svh"
module elts_sequencer #(
   parameter int ADDR_W = 16,
   parameter int BANK_W = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // protected array
   output elts_pkg::elts_mem_req_type mem_req,
   input wire elts_pkg::elts_mem_rsp_type mem_rsp
);
   import elts_pkg::*;
   typedef struct packed {
      elts_state_type st;
      logic [1:0] alg;
      logic bank_en;
      logic hold_dis;
      logic addr_pol;
      logic [7:0] loop_count_initial;
      logic [7:0] loop_cnt;
      logic [15:0] row_address_value;
      logic [7:0] bank_counter;
      logic [7:0] end_bank_number;
      logic [31:0] xor_mask;
      logic [31:0] fixed_pattern;
      logic [31:0] save_x;
      logic [31:0] save_y;
      logic [31:0] temp_hold_reg;
      logic fail;
      logic done;
      logic waiting;
      logic [31:0] rdata;
      logic ack_q;
      logic ue_q;
      logic ce_q;
      logic rd_ack;
   } elts_seq_state_type;
   elts_seq_state_type s;
   elts_seq_state_type next_s;
   logic issue;
   logic port_busy;
   elts_mem_req_type cmd;
   logic [15:0] cur_addr;
   logic [15:0] src_addr;
   logic [31:0] rd;
   logic access_done;

   // bank select bits sit on top of the row address in bank mode
   function automatic logic [15:0] form_addr(input logic [15:0] row,
                                             input logic [7:0] bank,
                                             input logic en);
      logic [15:0] a;
      a = row;
      if (en) begin
         a[15 -: BANK_W] = bank[BANK_W:1]; // see (RULE22)
      end
      return a;
   endfunction : form_addr

   function automatic elts_mem_req_type mk(input logic wr,
                                           input logic [1:0] path,
                                           input logic [15:0] addr,
                                           input logic [31:0] wd);
      elts_mem_req_type r;
      r.req = 1'b1;
      r.wr = wr;
      r.path = path; // see (RULE24)
      r.addr = addr;
      r.wdata = wd;
      return r;
   endfunction : mk

   // pattern inverted on odd passes gives base and inverse runs
   assign cur_addr = form_addr(s.row_address_value, s.bank_counter,
                               s.bank_en); // see (RULE20)
   assign src_addr = cur_addr ^ s.xor_mask[15:0]; // see (RULE1)
   assign rd = s.rdata;
   assign access_done = s.waiting && s.ack_q;
   // reads stall one cycle so the registered data stands on release
   assign avs_waitrequest = avs_read && !s.rd_ack;

   // memory command per state; issued once on entry
   always_comb begin
      cmd = '0;
      case (s.st)
         ST_SAVE_SRC: cmd = mk(1'b0, `ELTS_PATH_DIRECT,
                               (s.alg == `ELTS_ALG_DATA_LATENT) ? cur_addr :
                               src_addr, 32'h0); // see (RULE3)
         ST_GEN_WR: cmd = mk(1'b1, `ELTS_PATH_GEN,
                             (s.alg == `ELTS_ALG_DATA_LATENT) ? cur_addr :
                             src_addr, s.fixed_pattern); // see (RULE14)
         ST_SAVE_DST: cmd = mk(1'b0, `ELTS_PATH_DIRECT, cur_addr, 32'h0);
         ST_COPY_RD: cmd = mk(1'b0, `ELTS_PATH_DIRECT, src_addr, 32'h0);
         ST_COPY_WR: cmd = mk(1'b1, `ELTS_PATH_DIRECT, cur_addr,
                              s.temp_hold_reg); // see (RULE7)
         ST_DL_INJ: cmd = mk(1'b1, `ELTS_PATH_DIRECT, cur_addr,
                             s.save_y ^ s.xor_mask); // see (RULE18)
         ST_CHK_RD: cmd = mk(1'b0, `ELTS_PATH_CHECK,
                             (s.alg == `ELTS_ALG_ADDR_SPOINT) ? src_addr :
                             cur_addr, 32'h0); // see (RULE16)
         ST_DL_CORR: cmd = mk(1'b0, `ELTS_PATH_CORR, cur_addr, 32'h0);
         ST_RST_SRC: cmd = mk(1'b1, `ELTS_PATH_DIRECT,
                              (s.alg == `ELTS_ALG_DATA_LATENT) ? cur_addr :
                              src_addr, s.save_x); // see (RULE17)
         ST_RST_DST: cmd = mk(1'b1, `ELTS_PATH_DIRECT, cur_addr, s.save_y);
         ST_VER_SRC: cmd = mk(1'b0, `ELTS_PATH_DIRECT,
                              (s.alg == `ELTS_ALG_DATA_LATENT) ? cur_addr :
                              src_addr, 32'h0);
         ST_VER_DST: cmd = mk(1'b0, `ELTS_PATH_DIRECT, cur_addr, 32'h0);
         default: cmd = '0;
      endcase
   end

   assign issue = cmd.req && !s.waiting && !port_busy;

   // sequencer, register file and checks
   always_comb begin
      next_s = s;
      next_s.ack_q = mem_rsp.ack && port_busy;
      next_s.rd_ack = avs_read && !s.rd_ack;
      // flags only hold with ack, so keep them for the check state
      if (mem_rsp.ack && port_busy) begin
         next_s.rdata = mem_rsp.rdata;
         next_s.ue_q = mem_rsp.ue_flag;
         next_s.ce_q = mem_rsp.ce_flag;
      end
      if (issue) begin
         next_s.waiting = 1'b1;
      end
      if (access_done) begin
         next_s.waiting = 1'b0;
      end
      case (s.st)
         ST_IDLE: begin
            next_s.xor_mask = s.xor_mask;
         end
         ST_SAVE_SRC: if (access_done) begin
            next_s.save_x = rd;
            next_s.st = ST_GEN_WR;
         end
         ST_GEN_WR: if (access_done) begin
            if (s.alg == `ELTS_ALG_ADDR_SPOINT) begin
               next_s.st = ST_CHK_RD; // see (RULE15)
            end else begin
               next_s.st = ST_SAVE_DST;
            end
         end
         ST_SAVE_DST: if (access_done) begin
            next_s.save_y = rd;
            next_s.st = (s.alg == `ELTS_ALG_DATA_LATENT) ? ST_DL_INJ :
                        ST_COPY_RD;
         end
         ST_COPY_RD: if (access_done) begin
            // copy always passes the hold register; the disable bit is status
            next_s.temp_hold_reg = rd; // see (RULE7)
            next_s.st = ST_COPY_WR;
         end
         ST_COPY_WR, ST_DL_INJ: if (access_done) begin
            next_s.st = ST_CHK_RD;
         end
         ST_CHK_RD: if (access_done) begin
            case (s.alg)
               `ELTS_ALG_ADDR_SPOINT: begin
                  if (s.ue_q || s.ce_q) begin
                     next_s.fail = 1'b1; // see (RULE16) (RULE23)
                  end
               end
               `ELTS_ALG_DATA_LATENT: begin
                  if (s.ue_q || !s.ce_q) begin
                     next_s.fail = 1'b1; // see (RULE23)
                  end
               end
               default: begin
                  if (!(s.ue_q && !s.ce_q)) begin
                     next_s.fail = 1'b1; // see (RULE4) (RULE23)
                  end
               end
            endcase
            next_s.st = (s.alg == `ELTS_ALG_DATA_LATENT) ? ST_DL_CORR :
                        ST_RST_SRC;
         end
         ST_DL_CORR: if (access_done) begin
            if (rd != s.save_y) begin
               next_s.fail = 1'b1;
            end
            next_s.st = ST_RST_SRC;
         end
         ST_RST_SRC: if (access_done) begin
            next_s.st = (s.alg == `ELTS_ALG_ADDR_LATENT) ? ST_RST_DST :
                        ST_VER_SRC; // see (RULE5)
         end
         ST_RST_DST: if (access_done) begin
            next_s.st = ST_VER_SRC;
         end
         ST_VER_SRC: if (access_done) begin
            if (rd != s.save_x) begin
               next_s.fail = 1'b1; // see (RULE17) (RULE23)
            end
            next_s.st = ST_SHIFT;
         end
         ST_SHIFT: begin
            // even passes left, odd passes right
            if (s.bank_counter[0]) begin
               next_s.xor_mask = s.xor_mask << 1; // see (RULE12)
            end else begin
               next_s.xor_mask = s.xor_mask >> 1; // see (RULE12)
            end
            next_s.st = (s.alg == `ELTS_ALG_ADDR_LATENT) ? ST_VER_DST :
                        ST_LOOP;
         end
         ST_VER_DST: if (access_done) begin
            if (rd != s.save_y) begin
               next_s.fail = 1'b1; // see (RULE5) (RULE23)
            end
            next_s.st = ST_LOOP;
         end
         ST_LOOP: begin
            // data latent covers data plus code bits via loop count
            if (s.loop_cnt != 8'h00) begin
               next_s.loop_cnt = s.loop_cnt - 8'h01; // see (RULE13) (RULE19)
               next_s.st = ST_SAVE_SRC;
            end else begin
               next_s.loop_cnt = s.loop_count_initial;
               next_s.st = ST_PUP;
            end
         end
         ST_PUP: begin
            next_s.row_address_value = ~s.row_address_value; // see (RULE21)
            next_s.addr_pol = ~s.addr_pol;
            next_s.st = ST_LAST;
         end
         ST_LAST: begin
            // two passes per bank: counter counts half-banks
            if (s.bank_counter > {s.end_bank_number[6:0], 1'b0}) begin
               next_s.bank_counter = s.bank_counter - 8'h01; // see (RULE6)
               next_s.st = ST_SAVE_SRC;
            end else begin
               next_s.done = 1'b1;
               next_s.st = ST_IDLE;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
      // register writes, idle-only for config; start clears status
      if (avs_write && s.st == ST_IDLE) begin
         case ({3'h0, avs_address})
            8'(`ELTS_REG_CTRL): begin
               next_s.alg = avs_writedata[`ELTS_CTRL_ALG_HI:`ELTS_CTRL_ALG_LO];
               next_s.bank_en = avs_writedata[`ELTS_CTRL_BANKEN];
               next_s.hold_dis = avs_writedata[`ELTS_CTRL_HOLDDIS];
               next_s.addr_pol = avs_writedata[`ELTS_CTRL_POL];
               if (avs_writedata[`ELTS_CTRL_START]) begin
                  next_s.fail = 1'b0;
                  next_s.done = 1'b0;
                  next_s.loop_cnt = s.loop_count_initial;
                  next_s.st = ST_SAVE_SRC;
               end
            end
            8'(`ELTS_REG_LOOP): next_s.loop_count_initial = avs_writedata[7:0];
            8'(`ELTS_REG_ADDR):
               next_s.row_address_value = avs_writedata[15:0];
            8'(`ELTS_REG_BANK): begin
               next_s.bank_counter = avs_writedata[7:0]; // see (RULE10)
               next_s.end_bank_number = avs_writedata[15:8]; // see (RULE11)
            end
            8'(`ELTS_REG_MASK): next_s.xor_mask = avs_writedata; // see (RULE2)
            8'(`ELTS_REG_FPAT): next_s.fixed_pattern = avs_writedata;
            default: ;
         endcase
      end
   end

   // readback mux, registered
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !s.rd_ack) begin
         case ({3'h0, avs_address})
            8'(`ELTS_REG_CTRL): avs_readdata <= {26'h0, s.addr_pol,
               s.hold_dis, s.bank_en, s.alg, (s.st != ST_IDLE)};
            8'(`ELTS_REG_LOOP): avs_readdata <= {16'h0, s.loop_cnt,
                                                s.loop_count_initial};
            8'(`ELTS_REG_ADDR): avs_readdata <= {16'h0, s.row_address_value};
            8'(`ELTS_REG_BANK): avs_readdata <= {16'h0, s.end_bank_number,
                                                s.bank_counter};
            8'(`ELTS_REG_MASK): avs_readdata <= s.xor_mask;
            8'(`ELTS_REG_FPAT): avs_readdata <= s.fixed_pattern;
            8'(`ELTS_REG_STAT): avs_readdata <= {29'h0, (s.st != ST_IDLE),
                                                s.done, s.fail};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   elts_mem_port u_port (
      .mclk(mclk),
      .reset_n(reset_n),
      .issue(issue),
      .cmd(cmd),
      .busy(port_busy),
      .mem_req(mem_req),
      .mem_rsp(mem_rsp)
   );
endmodule : elts_sequencer

// ==== sim/elts_seq_props.sv ====
`timescale 1ns/1ps
module elts_seq_props (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // protected array
   input wire elts_pkg::elts_mem_req_type mem_req,
   input wire elts_pkg::elts_mem_rsp_type mem_rsp
);
   import elts_pkg::*;
   logic [1:0] alg;
   logic [31:0] fixed;
   elts_mem_req_type last;
   // run settings and last finished access; bus writes land here whether busy or idle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         alg <= 2'h0;
         fixed <= 32'h0;
         last <= '0;
      end else begin
         if (avs_write && avs_address == 5'h00)
            alg <= avs_writedata[2:1];
         if (avs_write && avs_address == 5'h14)
            fixed <= avs_writedata;
         if (mem_req.req && mem_rsp.ack)
            last <= mem_req;
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   property p_req_hold;
      mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request moved before ack");
   property p_req_release;
      mem_req.req && mem_rsp.ack |=> !mem_req.req;
   endproperty
   a_req_release: assert property (p_req_release)
      else $error("request kept after ack");
   property p_chk_read;
      mem_req.req && mem_req.path == 2'h2 |-> !mem_req.wr;
   endproperty
   a_chk_read: assert property (p_chk_read)
      else $error("write on checking path");
   property p_gen_fixed;
      mem_req.req && mem_req.path == 2'h1 && alg != 2'h2
         |-> mem_req.wr && mem_req.wdata == fixed;
   endproperty
   a_gen_fixed: assert property (p_gen_fixed)
      else $error("generation write not fixed pattern");
   property p_lat_dst;
      $rose(mem_req.req) && alg == 2'h0 && last.path == 2'h1
         |-> mem_req.path == 2'h0 && !mem_req.wr && mem_req.addr != last.addr;
   endproperty
   a_lat_dst: assert property (p_lat_dst)
      else $error("destination not saved after coded write");
   property p_sp_check;
      $rose(mem_req.req) && alg == 2'h1 && last.path == 2'h1
         |-> mem_req.path == 2'h2 && !mem_req.wr && mem_req.addr == last.addr;
   endproperty
   a_sp_check: assert property (p_sp_check)
      else $error("no checked read of written entry");
   property p_lat_restore;
      $rose(mem_req.req) && alg == 2'h0 && last.path == 2'h2
         && mem_req.path != 2'h2 |-> mem_req.path == 2'h0 && mem_req.wr;
   endproperty
   a_lat_restore: assert property (p_lat_restore)
      else $error("no direct restore after check");
   property p_sp_restore;
      $rose(mem_req.req) && alg == 2'h1 && last.path == 2'h2
         && mem_req.path != 2'h2
         |-> mem_req.path == 2'h0 && mem_req.wr && mem_req.addr == last.addr;
   endproperty
   a_sp_restore: assert property (p_sp_restore)
      else $error("saved entry not restored in place");
endmodule : elts_seq_props

bind elts_sequencer elts_seq_props i_props (
   .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_rsp(mem_rsp)
);

// ==== sim/elts_mem_model.sv ====
`timescale 1ns/1ps
module elts_mem_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // reply delay and fault to inject
   input wire logic [3:0] lat,
   input wire logic [1:0] fault,
   // sequencer link
   input wire elts_pkg::elts_mem_req_type mem_req,
   output elts_pkg::elts_mem_rsp_type mem_rsp
);
   import elts_pkg::*;
   // stored word, word as coded, address the code was made for
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] g;
      logic [15:0] a;
   } elts_ent_type;
   elts_ent_type mem [logic [15:0]];
   elts_ent_type e;
   elts_ent_type rd_last;
   logic [3:0] cnt;
   logic done;
   logic chk;
   logic hit;
   // one access at a time; reply lines toggle between answers so stale
   // data is never taken for a reply
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem_rsp <= '0;
         cnt = 4'h0;
         done = 1'b0;
      end else begin
         hit = 1'b0;
         if (!mem_req.req)
            done = 1'b0;
         else if (!done && cnt < lat)
            cnt = cnt + 4'h1;
         else if (!done) begin
            done = 1'b1;
            hit = 1'b1;
            cnt = 4'h0;
            if (mem.exists(mem_req.addr))
               e = mem[mem_req.addr];
            else
               e = {{mem_req.addr, ~mem_req.addr}, {mem_req.addr, ~mem_req.addr},
                    mem_req.addr};
            chk = !mem_req.wr && mem_req.path == 2'h2;
            if (mem_req.wr) begin
               if (mem_req.path == 2'h1)
                  e = {mem_req.wdata, mem_req.wdata, mem_req.addr};
               else if (mem_req.wdata == rd_last.d)
                  e = rd_last; // raw copy carries the source code along
               else
                  e.d = mem_req.wdata;
               if (fault == 2'h3 && mem_req.path == 2'h0)
                  e.d = ~e.d;
               mem[mem_req.addr] = e;
            end else if (mem_req.path == 2'h0)
               rd_last = e;
            mem_rsp.ack <= 1'b1;
            mem_rsp.rdata <= (mem_req.path == 2'h3) ? e.g : e.d;
            mem_rsp.ue_flag <= chk && ((e.a != mem_req.addr) ^ (fault == 2'h2));
            mem_rsp.ce_flag <= chk && ((e.a == mem_req.addr && e.d != e.g)
                                       || fault == 2'h1);
         end
         // idle cycles: drop ack and scramble the reply lines
         if (!hit) begin
            mem_rsp.ack <= 1'b0;
            mem_rsp.rdata <= ~mem_rsp.rdata;
            mem_rsp.ue_flag <= ~mem_rsp.ue_flag;
            mem_rsp.ce_flag <= ~mem_rsp.ce_flag;
         end
      end
   end
endmodule : elts_mem_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import elts_pkg::*;
   localparam logic [31:0] fixed_word = 32'h1234_5678;
   logic mclk;
   logic reset_n;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   elts_mem_req_type mem_req;
   elts_mem_rsp_type mem_rsp;
   logic [3:0] lat;
   logic [1:0] fault;
   logic armed;
   logic [31:0] d;
   int n_fail;
   int n_tests;
   elts_mem_req_type gq[$];
   elts_mem_req_type cq[$];

   elts_sequencer i_dut (
      .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_rsp(mem_rsp)
   );
   elts_mem_model i_mem (
      .mclk(mclk), .reset_n(reset_n), .lat(lat), .fault(fault),
      .mem_req(mem_req), .mem_rsp(mem_rsp)
   );

   always #12.5 mclk = ~mclk;

   // log coded writes and the first checked read after each of them
   always @(posedge mclk) begin
      if (reset_n && mem_req.req && mem_rsp.ack) begin
         if (mem_req.path == 2'h1 && mem_req.wr) begin
            gq.push_back(mem_req);
            armed = 1'b1;
         end else if (mem_req.path == 2'h2 && armed) begin
            cq.push_back(mem_req);
            armed = 1'b0;
         end
      end
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : wr

   // read data is taken at the edge where waitrequest is seen low
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd

   task automatic run(input logic [1:0] alg, input logic [7:0] lci, ca,
         input logic [31:0] m0, input logic [3:0] lt, input logic [1:0] flt,
         input logic ef);
      logic [31:0] st;
      logic [31:0] m;
      logic [15:0] dst;
      logic [7:0] cv;
      int k;
      int n;
      @(posedge mclk);
      lat <= lt;
      fault <= flt;
      gq.delete();
      cq.delete();
      wr(5'h04, {24'h0, lci});
      wr(5'h10, m0);
      wr(5'h08, 32'h0);
      wr(5'h0C, {24'h0, ca});
      wr(5'h14, fixed_word);
      wr(5'h00, {26'h0, 1'b0, alg != 2'h2, 1'b1, alg, 1'b1});
      st = 32'h4;
      k = 0;
      while (st[2:1] !== 2'b01 && k < 3000) begin
         rd(5'h18, st);
         k++;
      end
      check("done", {30'h0, st[2:1]}, 32'h1);
      check("fail", {31'h0, st[0]}, {31'h0, ef});
      if (flt == 2'h0) begin
         check("gens", 32'(gq.size()), (lci + 1) * (ca + 1));
         m = m0;
         n = 0;
         for (int p = 0; p <= ca && alg != 2'h2; p++) begin
            cv = ca - p[7:0];
            dst = {cv[4:1], p[0] ? 12'hFFF : 12'h000};
            for (int j = 0; j <= lci; j++) begin
               if (n < gq.size() && n < cq.size()) begin
                  check("gen addr", {16'h0, gq[n].addr},
                        {16'h0, dst ^ m[15:0]});
                  check("gen data", gq[n].wdata, fixed_word);
                  check("chk addr", {16'h0, cq[n].addr},
                        {16'h0, (alg == 2'h0) ? dst : dst ^ m[15:0]});
               end
               n++;
               m = cv[0] ? m << 1 : m >> 1;
            end
         end
      end
      $display("test alg %0d fault %0d end", alg, flt);
   endtask : run

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // faulty array first, then clean runs that must clear the sticky flag
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      lat = 4'h0;
      fault = 2'h0;
      armed = 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(5'h18, d);
      check("stat reset", d, 32'h0);
      rd(5'h1C, d);
      check("unmapped", d, 32'h0);
      wr(5'h14, 32'hFFFF_0000);
      rd(5'h14, d);
      check("pattern reg", d, 32'hFFFF_0000);
      run(2'h0, 8'h0, 8'h1, 32'h1, 4'h0, 2'h2, 1'b1);
      run(2'h0, 8'h0, 8'h1, 32'h1, 4'h1, 2'h1, 1'b1);
      run(2'h1, 8'h0, 8'h1, 32'h1, 4'h0, 2'h1, 1'b1);
      run(2'h1, 8'h0, 8'h1, 32'h1, 4'h2, 2'h3, 1'b1);
      run(2'h0, 8'h2, 8'h3, 32'h1, 4'h0, 2'h0, 1'b0);
      run(2'h0, 8'h1, 8'h1, 32'h3, 4'h3, 2'h0, 1'b0);
      run(2'h1, 8'h3, 8'h1, 32'h1, 4'h1, 2'h0, 1'b0);
      run(2'h2, 8'h3, 8'h1, 32'h1, 4'h0, 2'h0, 1'b0);
      tally_and_finish();
   end

   // hang guard, far beyond the few thousand cycles the runs need
   initial begin
      #(25 * 80000);
      n_fail++;
      tally_and_finish();
   end
endmodule : tb_top
